// file: rtl/pwi_sequencer.sv
// Power-up and power-down sequencer with write inhibit gate for a serial flash core.
`timescale 1ns/1ps
`include "pwi_map.svh"
module pwi_sequencer #(
    parameter int unsigned INHIBIT_CYCLES = `PWI_INHIBIT_CYCLES,
    parameter int unsigned SEL_CYCLES     = `PWI_SEL_DELAY_CYCLES
) (
    input  wire logic              ref_clk_in,        // Core clock, 25 MHz.
    input  wire logic              rstn_in,           // Asynchronous reset, active low.
    input  wire logic              por_ok_in,         // Supply above inhibit_threshold (pin level).
    input  wire logic              reset_pin_n_in,    // External reset pin, active low (pin level).
    input  wire logic              supply_min_in,     // Supply at or above minimum operating level (pin level).
    input  wire logic              cmd_valid_in,      // One-cycle strobe: decoded instruction present.
    input  wire pwi_pkg::pwi_cmd_t cmd_in,            // Decoded instruction.
    input  wire logic              wip_in,            // Write, program or erase cycle running.
    input  wire logic              cycle_done_in,     // One-cycle pulse: modifying cycle finished.
    output logic                   logic_run_out,     // Internal logic out of reset.
    output logic                   cmd_exec_out,      // One-cycle pulse: instruction accepted.
    output pwi_pkg::pwi_cmd_t      exec_cmd_out,      // Instruction accepted, valid with cmd_exec_out.
    output logic                   cmd_ignored_out,   // One-cycle pulse: instruction ignored.
    output logic                   abort_out,         // Running cycle cut off by supply loss.
    output logic                   write_enable_latch_out,
    output logic                   write_open_out,    // write_inhibit_delay elapsed.
    output logic                   read_open_out,     // select_after_supply_delay elapsed.
    output pwi_pkg::pwi_mode_t     mode_out,          // Power mode.
    output logic [7:0]             status_out,        // Status byte.
    output logic [7:0]             erased_byte_out    // Value of every array byte as shipped.
);
    import pwi_pkg::*;

    // -------------------------------------------------------------------------
    // Elaboration checks.
    // -------------------------------------------------------------------------
    if (INHIBIT_CYCLES < 1 || SEL_CYCLES < 1) begin : g_bad_params
        $error("Delay counts must be at least one cycle.");
    end

    // -------------------------------------------------------------------------
    // Pin synchronisers: supply level, reset pin and minimum supply.
    // -------------------------------------------------------------------------
    logic [2:0] sync1_q; // First stage, read only by the second stage.
    logic [2:0] sync2_q; // Second stage, safe to use.

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {supply_min_in, reset_pin_n_in, por_ok_in};
            sync2_q <= sync1_q;
        end
    end

    logic por_ok_s;     // Supply above threshold, synchronised.
    logic pin_run_s;    // Reset pin released, synchronised.
    logic supply_min_s; // Supply at minimum, synchronised.
    logic logic_run;    // Internal logic allowed to run.

    assign por_ok_s     = sync2_q[0];
    assign pin_run_s    = sync2_q[1];
    assign supply_min_s = sync2_q[2];
    // Power-on clear or the reset pin hold all logic in reset. [R1] [R9]
    assign logic_run    = por_ok_s & pin_run_s;

    // -------------------------------------------------------------------------
    // Delay timers: write inhibit and select-after-supply.
    // -------------------------------------------------------------------------
    pwi_gate_if inhibit_gate ();
    pwi_gate_if select_gate ();

    // Write inhibit counter starts once power-on clear and the reset pin are both released. [R12]
    assign inhibit_gate.run = logic_run;
    assign select_gate.run  = logic_run & supply_min_s;

    pwi_delay_timer #(.COUNT(INHIBIT_CYCLES)) u_inhibit_timer (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .gate       (inhibit_gate.timer)
    );

    pwi_delay_timer #(.COUNT(SEL_CYCLES)) u_select_timer (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .gate       (select_gate.timer)
    );

    logic write_open; // Modifying instructions permitted.
    logic read_open;  // Read instructions permitted.

    assign write_open = inhibit_gate.expired;
    assign read_open  = select_gate.expired;

    // -------------------------------------------------------------------------
    // Instruction gate.
    // -------------------------------------------------------------------------
    pwi_mode_t mode_q;  // Power mode.
    logic      wel_q;   // Write enable latch.
    logic      accept;  // Instruction accepted this cycle.
    logic      is_mod;  // Instruction modifies the array or lock store.

    // Decide whether a decoded instruction may run.
    always_comb begin
        is_mod = 1'b0;
        accept = 1'b0;
        case (cmd_in)
            pwi_page_rewrite_cmd, pwi_page_load_cmd, pwi_page_clear_cmd,
            pwi_block_clear_cmd, pwi_chip_clear_cmd, pwi_lock_store_cmd: begin
                is_mod = 1'b1;
            end
            default: begin
                is_mod = 1'b0;
            end
        endcase
        if (!cmd_valid_in || !logic_run) begin
            accept = 1'b0; // Nothing is answered while held in reset. [R1]
        end else if (mode_q == pwi_mode_deep_pd) begin
            // Deep power-down accepts only the release instruction, with the core idle; others are ignored.
            accept = (cmd_in == pwi_release_pd_cmd) && !wip_in;
        end else begin
            case (cmd_in)
                pwi_write_arm_cmd: begin
                    accept = write_open; // Arming is also inhibited. [R2]
                end
                pwi_read_cmd, pwi_read_status_cmd: begin
                    accept = read_open; // Reads need only the select delay. [R4]
                end
                pwi_write_disarm_cmd: begin
                    accept = 1'b1;
                end
                pwi_deep_pd_cmd, pwi_release_pd_cmd: begin
                    accept = !wip_in;
                end
                default: begin
                    // Modifying instructions need the gate open and the latch set. [R2] [R11]
                    accept = is_mod && write_open && wel_q && !wip_in;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Accept and ignore pulses with the accepted instruction.
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_exec_out    <= 1'b0;
            cmd_ignored_out <= 1'b0;
            exec_cmd_out    <= pwi_none_cmd;
        end else begin
            cmd_exec_out    <= accept;
            cmd_ignored_out <= cmd_valid_in && logic_run && !accept; // No ignore pulse in reset either. [R1]
            exec_cmd_out    <= accept ? cmd_in : pwi_none_cmd;
        end
    end

    // -------------------------------------------------------------------------
    // Power mode state machine.
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_q <= pwi_mode_reset;
        end else if (!logic_run) begin
            mode_q <= pwi_mode_reset; // Supply loss drops every mode. [R8]
        end else begin
            case (mode_q)
                pwi_mode_reset: begin
                    mode_q <= pwi_mode_standby; // Power-up lands in standby. [R6]
                end
                pwi_mode_standby: begin
                    if (accept && cmd_in == pwi_deep_pd_cmd) begin
                        mode_q <= pwi_mode_deep_pd;
                    end
                end
                pwi_mode_deep_pd: begin
                    if (accept && cmd_in == pwi_release_pd_cmd) begin
                        mode_q <= pwi_mode_standby;
                    end
                end
                default: begin
                    mode_q <= pwi_mode_reset;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Write enable latch: set by an accepted arm, set wins over clear.
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wel_q <= 1'b0;
        end else if (!logic_run) begin
            wel_q <= 1'b0; // Cleared at power-up. [R7]
        end else if (accept && cmd_in == pwi_write_arm_cmd) begin
            wel_q <= 1'b1; // Only a decoded arm sets it. [R11]
        end else if (cycle_done_in || (accept && cmd_in == pwi_write_disarm_cmd)) begin
            wel_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Supply-loss abort flag and registered status outputs.
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            abort_out <= 1'b0;
        end else begin
            abort_out <= !logic_run && wip_in; // Cycle cut off by supply loss. [R8]
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_out <= `PWI_STAT_RESET; // All usable status bits start at zero. [R10]
        end else if (!logic_run) begin
            status_out <= `PWI_STAT_RESET;
        end else begin
            status_out                   <= `PWI_STAT_RESET;
            status_out[`PWI_STAT_WIP_BIT] <= wip_in;
            status_out[`PWI_STAT_WEL_BIT] <= wel_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            logic_run_out  <= 1'b0;
            write_open_out <= 1'b0;
            read_open_out  <= 1'b0;
        end else begin
            logic_run_out  <= logic_run;
            write_open_out <= write_open;
            read_open_out  <= read_open;
        end
    end

    assign write_enable_latch_out = wel_q;
    assign mode_out               = mode_q;
    assign erased_byte_out        = `PWI_ERASED_BYTE; // Shipped array content. [R10]

    // -------------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    logic [31:0] run_age_q; // Cycles since logic_run rose, for checking only.

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_age_q <= 32'h0;
        end else if (!logic_run) begin
            run_age_q <= 32'h0;
        end else if (run_age_q != 32'hffffffff) begin
            run_age_q <= run_age_q + 32'h1;
        end
    end

    sequence s_arm_taken;
        cmd_valid_in && cmd_in == pwi_write_arm_cmd && accept;
    endsequence

    sequence s_mod_try;
        cmd_valid_in && logic_run && is_mod && mode_q != pwi_mode_deep_pd;
    endsequence

    property p_silent_in_reset;
        !logic_run |=> !cmd_exec_out && !cmd_ignored_out;
    endproperty
    a_silent_in_reset: assert property (p_silent_in_reset) else $error("Instruction run while held in reset."); // [R1]

    property p_inhibit_blocks;
        s_mod_try ##0 !write_open |=> cmd_ignored_out && !cmd_exec_out;
    endproperty
    a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("Modify accepted during inhibit delay."); // [R2]

    property p_gate_after_count;
        $rose(write_open) |-> run_age_q == INHIBIT_CYCLES;
    endproperty
    a_gate_after_count: assert property (p_gate_after_count) else $error("Inhibit gate opened at wrong count."); // [R12]

    property p_read_served;
        cmd_valid_in && cmd_in == pwi_read_cmd && logic_run && read_open
            && mode_q == pwi_mode_standby |=> cmd_exec_out && exec_cmd_out == pwi_read_cmd;
    endproperty
    a_read_served: assert property (p_read_served) else $error("Read refused after select delay."); // [R4]

    property p_standby_first;
        $rose(logic_run) |=> mode_q == pwi_mode_standby;
    endproperty
    a_standby_first: assert property (p_standby_first) else $error("Power-up did not enter standby."); // [R6]

    property p_wel_clear_up;
        $rose(logic_run) |-> !wel_q ##1 !wel_q;
    endproperty
    a_wel_clear_up: assert property (p_wel_clear_up) else $error("Latch set at power-up."); // [R7]

    property p_wel_by_arm;
        $rose(wel_q) |-> $past(cmd_valid_in) && $past(cmd_in) == pwi_write_arm_cmd;
    endproperty
    a_wel_by_arm: assert property (p_wel_by_arm) else $error("Latch set without arm."); // [R11]

    property p_arm_sets;
        s_arm_taken |=> wel_q [*2];
    endproperty
    a_arm_sets: assert property (p_arm_sets) else $error("Accepted arm did not hold latch."); // [R11]

    property p_drop_disables;
        $fell(logic_run) |-> ##1 (mode_q == pwi_mode_reset && !wel_q);
    endproperty
    a_drop_disables: assert property (p_drop_disables) else $error("Supply loss left state active."); // [R8]

    property p_status_zero;
        !logic_run |=> status_out == `PWI_STAT_RESET;
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("Status not zero in reset."); // [R10]

endmodule

// file: inc/pwi_map.svh
// Named offsets, field positions, reset values and timing figures of the power-on write inhibit block.
// How it works
// R1 - Below threshold, logic held reset, no instructions.
// R2 - Modifying and arming instructions ignored during inhibit delay.
// R3 - Host keeps select inactive until supply settles.
// R4 - Reads accepted once select-after-supply delay elapsed.
// R5 - Host sends no modify before both delays.
// R6 - Leaving reset enters standby, never deep power-down.
// R7 - Power-up clears the write enable latch.
// R8 - Supply loss disables all operations, aborts cycles.
// R9 - Host may hold reset pin low throughout.
// R10 - Shipped array reads FFh, status bits zero.
// R11 - Latch set only by decoded write arm.
// R12 - Inhibit delay is counter with configurable terminal.
`ifndef PWI_MAP_SVH
`define PWI_MAP_SVH

// -----------------------------------------------------------------------------
// Clock rate and timing figures.
// -----------------------------------------------------------------------------
`define PWI_CLK_KHZ            25000
`define PWI_INHIBIT_MIN_MS     1
`define PWI_INHIBIT_MAX_MS     10
`define PWI_SEL_DELAY_MIN_US   30
// A least time rounds up to whole clock cycles.
`define PWI_INHIBIT_CYCLES     ((`PWI_INHIBIT_MIN_MS * `PWI_CLK_KHZ))
`define PWI_SEL_DELAY_CYCLES   ((`PWI_SEL_DELAY_MIN_US * `PWI_CLK_KHZ + 999) / 1000)

// -----------------------------------------------------------------------------
// Status byte layout and reset values.
// -----------------------------------------------------------------------------
`define PWI_STAT_WIP_BIT       0
`define PWI_STAT_WEL_BIT       1
`define PWI_STAT_RESET         8'h00
`define PWI_ERASED_BYTE        8'hff
`define PWI_SYNC_STAGES        2

`endif

// file: inc/pwi_pkg.sv
// Types shared by the power-on write inhibit block.
package pwi_pkg;

    // Decoded instructions handed over by the instruction decoder.
    typedef enum logic [3:0] {
        pwi_none_cmd,
        pwi_write_arm_cmd,
        pwi_write_disarm_cmd,
        pwi_page_rewrite_cmd,
        pwi_page_load_cmd,
        pwi_page_clear_cmd,
        pwi_block_clear_cmd,
        pwi_chip_clear_cmd,
        pwi_lock_store_cmd,
        pwi_read_cmd,
        pwi_read_status_cmd,
        pwi_deep_pd_cmd,
        pwi_release_pd_cmd
    } pwi_cmd_t;

    // Power mode of the device.
    typedef enum logic [1:0] {
        pwi_mode_reset,
        pwi_mode_standby,
        pwi_mode_deep_pd
    } pwi_mode_t;

endpackage

// file: inc/pwi_gate_if.sv
// Interface between the sequencer and one of its delay timers.
`timescale 1ns/1ps
interface pwi_gate_if;
    logic run;     // Timer counts while high, clears while low.
    logic expired; // High once the terminal count is reached.

    modport owner (output run, input expired);
    modport timer (input run, output expired);
endinterface

// file: rtl/pwi_delay_timer.sv
// Delay timer that opens a gate a fixed number of cycles after its run level rises.
`timescale 1ns/1ps
module pwi_delay_timer #(
    parameter int unsigned COUNT = 1
) (
    input  wire logic     ref_clk_in,
    input  wire logic     rstn_in,
    pwi_gate_if.timer     gate
);
    import pwi_pkg::*;

    // -------------------------------------------------------------------------
    // Elaboration check.
    // -------------------------------------------------------------------------
    if (COUNT < 1) begin : g_bad_count
        $error("Timer terminal count must be at least one cycle.");
    end

    localparam int unsigned CW = $clog2(COUNT + 1);

    logic [CW-1:0] count_q; // Cycles elapsed since run rose.
    logic          open_q;  // Terminal count reached.

    // -------------------------------------------------------------------------
    // Counter: cleared while run is low, saturates at the terminal count.
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_q <= '0;
            open_q  <= 1'b0;
        end else if (!gate.run) begin
            count_q <= '0;
            open_q  <= 1'b0;
        end else if (count_q != CW'(COUNT)) begin
            count_q <= count_q + CW'(1);
            open_q  <= (count_q == CW'(COUNT - 1));
        end
    end

    assign gate.expired = open_q;

endmodule

// file: dv/pwi_host_model.sv
// Behavioural model of the serial host controller that issues decoded instructions to the sequencer.
`timescale 1ns/1ps
module pwi_host_model
    import pwi_pkg::*;
#(
    parameter int unsigned SEL_CYCLES = 9
) (
    input  wire logic     ref_clk_in,        // Core clock.
    input  wire logic     supply_min_in,     // Supply at minimum operating level.
    input  wire logic     cmd_exec_in,       // Accept pulse from the sequencer.
    input  wire pwi_cmd_t exec_cmd_in,       // Accepted instruction.
    input  wire logic     cmd_ignored_in,    // Ignore pulse from the sequencer.
    output logic          cmd_valid_out,     // Instruction strobe.
    output pwi_cmd_t      cmd_out,           // Instruction code.
    output logic          reset_pin_n_out    // Reset pin, active low.
);
    int unsigned sup_cnt = 0;                // Cycles since supply reached its minimum.

    // -------------------------------------------------------------------------
    // Supply watch.
    // -------------------------------------------------------------------------
    // Counts how long the supply has been good; a drop restarts the count.
    always @(posedge ref_clk_in) begin
        if (!supply_min_in) begin
            sup_cnt <= 0;
        end else if (sup_cnt < SEL_CYCLES) begin
            sup_cnt <= sup_cnt + 1;
        end
    end

    // Reset pin held low through power-up until the bench lets it go.
    initial begin
        cmd_valid_out   = 1'b0;
        cmd_out         = pwi_none_cmd;
        reset_pin_n_out = 1'b0;
    end

    // Sends one instruction and reports the answer as {accepted, ignored}.
    // Unless early is set, selection waits for the supply delay first.
    // Modifying instructions are only sent early when the bench means it.
    task automatic issue(input pwi_cmd_t c, input bit early, output logic [1:0] res, output pwi_cmd_t got);
        int n;
        n = 0;
        while (!early && sup_cnt < SEL_CYCLES && n < 1000) begin
            @(negedge ref_clk_in);
            n++;
        end
        @(negedge ref_clk_in);
        cmd_valid_out = 1'b1;
        cmd_out       = c;
        // The answer stands only in the cycle after the strobe edge, so it is taken here.
        @(negedge ref_clk_in);
        res = (n < 1000) ? {cmd_exec_in, cmd_ignored_in} : 2'b11; // A spent wait never matches.
        got = exec_cmd_in;
        cmd_valid_out = 1'b0;
        cmd_out       = pwi_cmd_t'(~c); // Released code lines do not keep the last value.
    endtask
endmodule

// file: dv/tb.sv
// Self-checking testbench of the power-on write inhibit sequencer.
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module tb;
    import pwi_pkg::*;
    localparam int unsigned INH = 20;          // Shortened inhibit count.
    localparam int unsigned SEL = 5;           // Shortened select delay.
    localparam logic [1:0]  ACC = 2'b10;       // Instruction accepted.
    localparam logic [1:0]  IGN = 2'b01;       // Instruction ignored.
    localparam logic [1:0]  NON = 2'b00;       // No answer at all.

    logic ref_clk = 1'b0, rstn = 1'b0, por_ok = 1'b0, sup_min = 1'b0, wip = 1'b0, done = 1'b0;
    logic cmd_valid, pin_n, run, exec, ign, abort_o, latch, wopen, ropen;
    pwi_cmd_t  cmd, exec_cmd;
    pwi_mode_t mode;
    logic [7:0] status, erased;
    logic [1:0] res;
    pwi_cmd_t   got;
    int bad_count = 0;
    int check_count = 0;
    pwi_cmd_t mods [6] = '{pwi_page_rewrite_cmd, pwi_page_load_cmd, pwi_page_clear_cmd,
                           pwi_block_clear_cmd, pwi_chip_clear_cmd, pwi_lock_store_cmd};

    // Clock generator, 40 ns period.
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    pwi_sequencer #(.INHIBIT_CYCLES(INH), .SEL_CYCLES(SEL)) pwi_sequencer_i (
        .ref_clk_in(ref_clk), .rstn_in(rstn), .por_ok_in(por_ok), .reset_pin_n_in(pin_n),
        .supply_min_in(sup_min), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .wip_in(wip),
        .cycle_done_in(done), .logic_run_out(run), .cmd_exec_out(exec), .exec_cmd_out(exec_cmd),
        .cmd_ignored_out(ign), .abort_out(abort_o), .write_enable_latch_out(latch),
        .write_open_out(wopen), .read_open_out(ropen), .mode_out(mode), .status_out(status),
        .erased_byte_out(erased));

    // The host waits a few cycles beyond the select delay to cover the pin synchronisers.
    pwi_host_model #(.SEL_CYCLES(SEL + 4)) pwi_host_model_i (
        .ref_clk_in(ref_clk), .supply_min_in(sup_min), .cmd_exec_in(exec), .exec_cmd_in(exec_cmd),
        .cmd_ignored_in(ign), .cmd_valid_out(cmd_valid), .cmd_out(cmd), .reset_pin_n_out(pin_n));

    // -------------------------------------------------------------------------
    // Shared helpers.
    // -------------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Waits at falling edges until run equals v; returns the cycles taken, or gives up.
    task automatic wait_run(input logic v, output int n);
        n = 0;
        while (run !== v) begin
            @(negedge ref_clk);
            n++;
            if (n > 50) begin
                `CHK(run, v, "run level never reached")
                conclude();
            end
        end
    endtask

    // Sends one instruction and compares the answer.
    task automatic send(input pwi_cmd_t c, input bit early, input logic [1:0] exp, input string m);
        pwi_host_model_i.issue(c, early, res, got);
        `CHK(res, exp, m)
        if (exp == ACC) begin
            `CHK(got, c, "accepted code differs")
        end
    endtask

    // -------------------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------------------
    // Below threshold: logic held reset, silent, shipped values visible.
    task automatic t_below_threshold();
        `CHK(run, 1'b0, "logic runs below threshold")
        `CHK(mode, pwi_mode_reset, "mode not reset")
        `CHK(erased, 8'hff, "erased byte wrong")
        `CHK(status, 8'h00, "status not clear")
        `CHK(ropen, 1'b0, "read gate open below threshold")
        send(pwi_write_arm_cmd, 1'b1, NON, "answer while held in reset");
        send(pwi_read_cmd, 1'b1, NON, "read answered while held in reset");
    endtask

    // Power-up: standby, reads before writes, inhibit counted.
    task automatic t_powerup();
        int n;
        int w;
        @(negedge ref_clk);
        sup_min = 1'b1;
        por_ok  = 1'b1;
        pwi_host_model_i.reset_pin_n_out = 1'b1;
        wait_run(1'b1, n);
        @(negedge ref_clk);
        `CHK(mode, pwi_mode_standby, "not standby after power-up")
        `CHK(latch, 1'b0, "latch set after power-up")
        send(pwi_read_cmd, 1'b0, ACC, "read refused after select delay");
        `CHK(ropen, 1'b1, "read gate closed after select delay")
        send(pwi_read_status_cmd, 1'b0, ACC, "status read refused");
        `CHK(wopen, 1'b0, "write gate open too soon")
        send(pwi_write_arm_cmd, 1'b1, IGN, "arm taken during inhibit");
        send(pwi_page_load_cmd, 1'b1, IGN, "modify taken during inhibit");
        w = 15;
        while (wopen !== 1'b1 && w < 200) begin
            @(negedge ref_clk);
            w++;
        end
        `CHK((w >= INH) && (w <= INH + 3), 1'b1, "inhibit length wrong")
    endtask

    // Every modifying instruction needs a fresh arm and an idle core.
    task automatic t_modify();
        foreach (mods[i]) begin
            send(mods[i], 1'b0, IGN, "modify taken without latch");
            send(pwi_write_arm_cmd, 1'b0, ACC, "arm refused");
            `CHK(latch, 1'b1, "latch not set by arm")
            wip = 1'b1;
            send(mods[i], 1'b0, IGN, "modify taken while busy");
            `CHK(status, 8'h03, "status bits wrong while busy")
            wip = 1'b0;
            send(mods[i], 1'b0, ACC, "modify refused with latch");
            done = 1'b1;
            @(negedge ref_clk);
            done = 1'b0;
            @(negedge ref_clk);
            `CHK(latch, 1'b0, "latch kept after cycle end")
        end
    endtask

    // Deep power-down lost over a supply cycle; gate re-armed.
    task automatic t_deep_cycle();
        int n;
        send(pwi_deep_pd_cmd, 1'b0, ACC, "deep power-down refused");
        `CHK(mode, pwi_mode_deep_pd, "not in deep power-down")
        send(pwi_read_cmd, 1'b0, IGN, "read taken in deep power-down");
        por_ok = 1'b0;
        wait_run(1'b0, n);
        send(pwi_read_status_cmd, 1'b1, NON, "answer after supply loss");
        `CHK(mode, pwi_mode_reset, "mode kept after supply loss")
        por_ok = 1'b1;
        wait_run(1'b1, n);
        @(negedge ref_clk);
        `CHK(mode, pwi_mode_standby, "came back in deep power-down")
        `CHK(wopen, 1'b0, "write gate kept over supply loss")
        `CHK(latch, 1'b0, "latch kept over supply loss")
    endtask

    // Supply loss during a busy core aborts it; reset pin holds logic off.
    task automatic t_abort();
        int n;
        wip    = 1'b1;
        por_ok = 1'b0;
        n = 0;
        while (abort_o !== 1'b1 && n < 6) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(abort_o, 1'b1, "no abort on supply loss")
        `CHK(run, 1'b0, "logic runs after supply loss")
        wip    = 1'b0;
        por_ok = 1'b1;
        pwi_host_model_i.reset_pin_n_out = 1'b0;
        repeat (8) @(negedge ref_clk);
        `CHK(run, 1'b0, "logic runs with reset pin low")
        send(pwi_read_cmd, 1'b1, NON, "answer with reset pin low");
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_below_threshold();
        t_powerup();
        t_modify();
        t_deep_cycle();
        t_abort();
        conclude();
    end
endmodule
